// ==== core/hmrb_core.v ====
// hyp protection region base registers, region count register and system control access decode
// assumes the core pipeline presents one coprocessor access per valid cycle, from clk_sys logic
`timescale 1ns/1ns
`include "hmrb_regs.vh"

module hmrb_core
(
	// clock and reset
	input  wire        clk_sys,
	input  wire        resetn,
	// coprocessor access request
	input  wire        reqValid,
	input  wire        reqWrite,
	input  wire [1:0]  reqLevel,
	input  wire [3:0]  reqCoproc,
	input  wire [2:0]  reqOpc1,
	input  wire [3:0]  reqCrn,
	input  wire [3:0]  reqCrm,
	input  wire [2:0]  reqOpc2,
	input  wire [31:0] reqWdata,
	// trap and translation controls
	input  wire        hypLevelPresent,
	input  wire        generalExceptionTrap,
	input  wire        virtMemWriteTrap,
	input  wire        virtMemReadTrap,
	input  wire        hypGroup0Trap,
	input  wire        hypGroup1Trap,
	input  wire        hypGroup6Trap,
	input  wire        stage2Enable,
	input  wire [7:0]  regionSelector,
	// permission check on the selected region
	input  wire [1:0]  chkLevel,
	input  wire        chkWrite,
	input  wire        chkStage1Allow,
	// access response
	output reg         rspValid,
	output reg  [31:0] rspRdata,
	output reg         rspTrapHyp,
	output reg         rspUndef,
	output reg         rspSysCtl,
	output reg         rspSysCtlWrite,
	// selected region attributes
	output reg  [31:0] selBaseAddr,
	output reg  [1:0]  selShareability,
	output reg         selShareReserved,
	output reg         selExecuteNever,
	output reg         chkAllow
);

////////////////////////////////////////////////////////////////////////////////
// helpers

function match;
	input [3:0] cp;
	input [2:0] o1;
	input [3:0] cn;
	input [3:0] cm;
	input [2:0] o2;
	input [2:0] e1;
	input [3:0] en;
	input [3:0] em;
	input [2:0] e2;
	begin
		match = (cp == `HMRB_COPROC) && (o1 == e1) && (cn == en) && (cm == em) && (o2 == e2);
	end
endfunction

// permission decode of one region for one access
function permOk;
	input [1:0] perm;
	input [1:0] lvl;
	input       wr;
	begin
		if (lvl == `HMRB_LVL_HYP)
			permOk = ~(wr & perm[1]);
		else
			permOk = perm[0] & ~(wr & perm[1]);
	end
endfunction

// region index inside the implemented count
function implemented;
	input [7:0] idx;
	begin
		implemented = (idx < `HMRB_NUM_REGIONS);
	end
endfunction

// kernel access to a hyp-owned register with its group trap set
function hypTrap;
	input open;
	input present;
	input grp;
	begin
		hypTrap = open & present & grp;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// decode

reg  [31:0] regionBase [0:`HMRB_NUM_REGIONS-1];

wire        hitSysCtl;
wire        hitCount;
wire        hitSel;
wire        hitDir;
wire [4:0]  dirIndex;
wire        dirImpl;
wire        selImpl;
wire        isKernel;
wire        isHyp;
wire        kernelOpen;
wire [7:0]  selIndex;

assign hitSysCtl = match(reqCoproc, reqOpc1, reqCrn, reqCrm, reqOpc2,
	`HMRB_SCR_OPC1, `HMRB_SCR_CRN, `HMRB_SCR_CRM, `HMRB_SCR_OPC2);
assign hitCount  = match(reqCoproc, reqOpc1, reqCrn, reqCrm, reqOpc2,
	`HMRB_CNT_OPC1, `HMRB_CNT_CRN, `HMRB_CNT_CRM, `HMRB_CNT_OPC2);
assign hitSel    = match(reqCoproc, reqOpc1, reqCrn, reqCrm, reqOpc2,
	`HMRB_SEL_OPC1, `HMRB_SEL_CRN, `HMRB_SEL_CRM, `HMRB_SEL_OPC2);
assign hitDir    = (reqCoproc == `HMRB_COPROC) && (reqCrn == `HMRB_DIR_CRN)
	&& (reqOpc1[2:1] == `HMRB_DIR_OPC1_HI) && (reqCrm[3] == `HMRB_DIR_CRM_HI)
	&& (reqOpc2[1:0] == `HMRB_DIR_OPC2_LO);
assign dirIndex  = {reqOpc1[0], reqCrm[2:0], reqOpc2[2]};
assign dirImpl   = implemented({3'h0, dirIndex});
assign selIndex  = regionSelector;
assign selImpl   = implemented(selIndex);
assign isKernel  = (reqLevel == `HMRB_LVL_KERNEL);
assign isHyp     = (reqLevel == `HMRB_LVL_HYP);
assign kernelOpen = isKernel & ~generalExceptionTrap;

////////////////////////////////////////////////////////////////////////////////
// access outcome

reg         next_trap;
reg         next_undef;
reg         next_write;
reg  [31:0] next_rdata;
reg  [4:0]  wrIndex;

always @*
begin
	next_trap  = 1'b0;
	next_undef = 1'b0;
	next_write = 1'b0;
	next_rdata = `HMRB_RST_DATA;
	wrIndex    = 5'h00;
	if (hitSysCtl)
	begin
		if (kernelOpen)
			next_trap = hypGroup1Trap
				| (reqWrite & virtMemWriteTrap)
				| (~reqWrite & virtMemReadTrap);
		else if (!isHyp)
			next_undef = 1'b1;
	end
	else if (hitCount)
	begin
		if (isHyp)
			next_rdata = {24'h000000, `HMRB_NUM_REGIONS};
		else if (hypTrap(kernelOpen, hypLevelPresent, hypGroup0Trap))
			next_trap = 1'b1;
		else
			next_undef = 1'b1;
	end
	else if (hitSel)
	begin
		if (isHyp)
		begin
			next_write = reqWrite & selImpl;
			wrIndex    = selIndex[4:0];
			if (selImpl)
				next_rdata = regionBase[selIndex[3:0]];
		end
		else if (hypTrap(kernelOpen, hypLevelPresent, hypGroup6Trap))
			next_trap = 1'b1;
		else
			next_undef = 1'b1;
	end
	else if (hitDir)
	begin
		if (!dirImpl)
			next_undef = 1'b1;
		else if (isHyp)
		begin
			next_write = reqWrite;
			wrIndex    = dirIndex;
			next_rdata = regionBase[dirIndex[3:0]];
		end
		else if (hypTrap(kernelOpen, hypLevelPresent, hypGroup6Trap))
			next_trap = 1'b1;
		else
			next_undef = 1'b1;
	end
	else
		next_undef = 1'b1;
end

////////////////////////////////////////////////////////////////////////////////
// region storage, no reset so fields start unknown

wire        wrEnable;
wire [31:0] wrWord;

assign wrEnable = reqValid & next_write;
assign wrWord   = reqWdata & `HMRB_BASE_WMASK;

always @(posedge clk_sys)
begin
	if (wrEnable)
		regionBase[wrIndex[3:0]] <= wrWord;
end

////////////////////////////////////////////////////////////////////////////////
// response

wire        sysCtlGrant;

assign sysCtlGrant = reqValid & hitSysCtl & ~next_trap & ~next_undef;

always @(posedge clk_sys or negedge resetn)
begin
	if (!resetn)
	begin
		rspValid       <= 1'b0;
		rspRdata       <= `HMRB_RST_DATA;
		rspTrapHyp     <= 1'b0;
		rspUndef       <= 1'b0;
		rspSysCtl      <= 1'b0;
		rspSysCtlWrite <= 1'b0;
	end
	else
	begin
		rspValid       <= reqValid;
		rspRdata       <= (reqValid && !reqWrite) ? next_rdata : `HMRB_RST_DATA;
		rspTrapHyp     <= reqValid & next_trap;
		rspUndef       <= reqValid & next_undef;
		rspSysCtl      <= sysCtlGrant;
		rspSysCtlWrite <= sysCtlGrant & reqWrite;
	end
end

////////////////////////////////////////////////////////////////////////////////
// selected region attributes and permission check

wire [31:0] selWord;
wire        selPerm;
wire        selAllow;
wire [1:0]  selShare;
wire        hypCheck;

assign selWord  = selImpl ? regionBase[selIndex[3:0]] : `HMRB_RST_DATA;
assign selPerm  = permOk(selWord[`HMRB_PERM_MSB:`HMRB_PERM_LSB], chkLevel, chkWrite);
assign selAllow = selImpl & selPerm;
assign selShare = selWord[`HMRB_SHARE_MSB:`HMRB_SHARE_LSB];
assign hypCheck = (chkLevel == `HMRB_LVL_HYP);

always @(posedge clk_sys or negedge resetn)
begin
	if (!resetn)
	begin
		selBaseAddr      <= `HMRB_RST_DATA;
		selShareability  <= `HMRB_SHARE_NON;
		selShareReserved <= 1'b0;
		selExecuteNever  <= 1'b0;
		chkAllow         <= 1'b0;
	end
	else
	begin
		selBaseAddr      <= {selWord[`HMRB_BASE_MSB:`HMRB_BASE_LSB], 6'h00};
		selShareability  <= selShare;
		selShareReserved <= (selShare == `HMRB_SHARE_RSVD);
		selExecuteNever  <= selWord[`HMRB_EXEC_NEVER_BIT];
		if (hypCheck)
			chkAllow <= selAllow;
		else if (stage2Enable)
			chkAllow <= selAllow & chkStage1Allow;
		else
			chkAllow <= chkStage1Allow;
	end
end

endmodule // hmrb_core

// ==== core/hmrb_regs.vh ====
// encodings and field positions of the hyp region base registers, and output reset values
// assumes inclusion by hmrb_core.v only
`ifndef HMRB_REGS_VH
`define HMRB_REGS_VH

// coprocessor number shared by all registers
`define HMRB_COPROC           4'hF
// system control register
`define HMRB_SCR_OPC1         3'h0
`define HMRB_SCR_CRN          4'h1
`define HMRB_SCR_CRM          4'h0
`define HMRB_SCR_OPC2         3'h0
// region-count identification register
`define HMRB_CNT_OPC1         3'h4
`define HMRB_CNT_CRN          4'h0
`define HMRB_CNT_CRM          4'h0
`define HMRB_CNT_OPC2         3'h4
// selected-region base register
`define HMRB_SEL_OPC1         3'h4
`define HMRB_SEL_CRN          4'h6
`define HMRB_SEL_CRM          4'h3
`define HMRB_SEL_OPC2         3'h0
// directly indexed base registers
`define HMRB_DIR_CRN          4'h6
`define HMRB_DIR_OPC1_HI      2'h0
`define HMRB_DIR_CRM_HI       1'h1
`define HMRB_DIR_OPC2_LO      2'h0
`define HMRB_DIR_COUNT        6'h20
// implemented region count, reported in bits [7:0]
`define HMRB_NUM_REGIONS      8'h10
`define HMRB_CNT_MSB          7
// base register fields
`define HMRB_BASE_MSB         31
`define HMRB_BASE_LSB         6
`define HMRB_RES_BIT          5
`define HMRB_SHARE_MSB        4
`define HMRB_SHARE_LSB        3
`define HMRB_PERM_MSB         2
`define HMRB_PERM_LSB         1
`define HMRB_EXEC_NEVER_BIT   0
`define HMRB_BASE_WMASK       32'hFFFFFFDF
// shareability codes
`define HMRB_SHARE_NON        2'h0
`define HMRB_SHARE_RSVD       2'h1
`define HMRB_SHARE_OUTER      2'h2
`define HMRB_SHARE_INNER      2'h3
// exception levels
`define HMRB_LVL_USER         2'h0
`define HMRB_LVL_KERNEL       2'h1
`define HMRB_LVL_HYP          2'h2
// output reset values
`define HMRB_RST_DATA         32'h00000000
`endif

// ==== tb/hmrb_core_monitor.sv ====
// checker on the coprocessor port of hmrb_core
// assumes one clock clk_sys and resetn asynchronous active low
`timescale 1ns/1ns
module hmrb_core_monitor
(
	// clock and reset
	input wire        clk_sys,
	input wire        resetn,
	// request and controls
	input wire        reqValid,
	input wire        reqWrite,
	input wire [1:0]  reqLevel,
	input wire [3:0]  reqCoproc,
	input wire [2:0]  reqOpc1,
	input wire [3:0]  reqCrn,
	input wire [3:0]  reqCrm,
	input wire [2:0]  reqOpc2,
	input wire        hypLevelPresent,
	input wire        generalExceptionTrap,
	input wire        virtMemWriteTrap,
	input wire        virtMemReadTrap,
	input wire        hypGroup0Trap,
	input wire        hypGroup1Trap,
	input wire        hypGroup6Trap,
	// response
	input wire        rspValid,
	input wire [31:0] rspRdata,
	input wire        rspTrapHyp,
	input wire        rspUndef,
	input wire        rspSysCtl,
	input wire        rspSysCtlWrite
);
	wire [17:0] enc = {reqCoproc, reqOpc1, reqCrn, reqCrm, reqOpc2};
	wire        kAcc = reqValid && reqLevel == 2'h1 && !generalExceptionTrap;
	wire        isScr = enc == {4'hF, 3'h0, 4'h1, 4'h0, 3'h0};
	wire        isCnt = enc == {4'hF, 3'h4, 4'h0, 4'h0, 3'h4};
	wire        isSel = enc == {4'hF, 3'h4, 4'h6, 4'h3, 3'h0};
	wire        hiDir = enc[17:7] == {4'hF, 2'h0, 1'h1, 4'h6} && reqCrm[3] && reqOpc2[1:0] == 2'h0;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_idle_silent: assert property (!reqValid |=> !rspValid && !rspUndef && !rspTrapHyp)
		else $error("response without request");
	a_scr_wtrap: assert property (kAcc && isScr && reqWrite && virtMemWriteTrap |=> rspTrapHyp)
		else $error("control write not trapped");
	a_scr_rtrap: assert property (kAcc && isScr && !reqWrite && virtMemReadTrap |=> rspTrapHyp)
		else $error("control read not trapped");
	a_grp1_trap: assert property (kAcc && isScr && hypGroup1Trap |=> rspTrapHyp && !rspSysCtl)
		else $error("group1 trap missed");
	a_scr_grant: assert property (kAcc && isScr && !hypGroup1Trap && !virtMemWriteTrap && !virtMemReadTrap
		|=> rspSysCtl && rspSysCtlWrite == $past(reqWrite))
		else $error("control access not granted");
	a_count_value: assert property (reqValid && !reqWrite && reqLevel == 2'h2 && isCnt
		|=> rspValid ##0 rspRdata == 32'h10)
		else $error("region count wrong");
	a_grp0_trap: assert property (kAcc && isCnt && hypLevelPresent && hypGroup0Trap |=> rspTrapHyp)
		else $error("group0 trap missed");
	a_grp6_trap: assert property (kAcc && isSel && hypLevelPresent && hypGroup6Trap |=> rspTrapHyp)
		else $error("group6 trap missed");
	a_dir_unalloc: assert property (reqValid && hiDir |=> rspUndef && !rspTrapHyp && rspRdata == 32'h0)
		else $error("high direct index allocated");
	c_grant: cover property (kAcc && isScr ##1 rspSysCtl);
	c_trap: cover property (kAcc && isSel ##1 rspTrapHyp);
	c_count: cover property (reqValid && isCnt ##1 rspValid);
endmodule // hmrb_core_monitor
bind hmrb_core hmrb_core_monitor mon (.*);

// ==== tb/hmrb_core_tb.sv ====
// self-checking bench for hmrb_core, driven at falling edges
// assumes hmrb_pipe_model issues requests and 16 implemented regions
`timescale 1ns/1ns
module hmrb_core_tb;
	reg clk_sys = 1'b0, resetn = 1'b0;
	reg hypLevelPresent = 1'b1, generalExceptionTrap = 1'b0, virtMemWriteTrap = 1'b0, virtMemReadTrap = 1'b0;
	reg hypGroup0Trap = 1'b0, hypGroup1Trap = 1'b0, hypGroup6Trap = 1'b0, stage2Enable = 1'b0, chkWrite = 1'b0;
	reg chkStage1Allow = 1'b0;
	reg [7:0] regionSelector = 8'h0;
	reg [1:0] chkLevel = 2'h2;
	wire reqValid, reqWrite, rspValid, rspTrapHyp, rspUndef, rspSysCtl, rspSysCtlWrite;
	wire selShareReserved, selExecuteNever, chkAllow;
	wire [1:0] reqLevel, selShareability;
	wire [3:0] reqCoproc, reqCrn, reqCrm;
	wire [2:0] reqOpc1, reqOpc2;
	wire [31:0] reqWdata, rspRdata, selBaseAddr;
	reg [31:0] d, mem[0:15];
	reg [3:0] x;
	integer seed = 32'h6FD63B2B, i, j, nErrors = 0, testsRun = 0, cyc = 0;
	localparam [17:0] SCR = {4'hF, 3'h0, 4'h1, 4'h0, 3'h0};
	localparam [17:0] CNT = {4'hF, 3'h4, 4'h0, 4'h0, 3'h4};
	localparam [17:0] SEL = {4'hF, 3'h4, 4'h6, 4'h3, 3'h0};
	hmrb_core dut (.*);
	hmrb_pipe_model m (.*);
	always #2 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	function [17:0] dir(input [4:0] n);
		dir = {4'hF, 2'h0, n[4], 4'h6, 1'h1, n[3:1], n[0], 2'h0};
	endfunction
	task cmp(input [39:0] a, input [39:0] b, input string s);
	begin
		testsRun++;
		if (a !== b)
		begin
			nErrors++;
			$display("ERROR %0t %s", $time, s);
		end
	end
	endtask
	task printVerdict;
	begin
		$display("checks %0d errors %0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask
	// response watcher: oldest note against each answer
	always @(negedge clk_sys)
		if (rspValid === 1'b1)
			cmp({rspUndef, rspTrapHyp, rspSysCtl, rspSysCtlWrite, rspRdata},
				m.expQ.size() ? m.expQ.pop_front() : 36'hF, "response mismatch");
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			nErrors++;
			printVerdict;
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys) resetn = 1'b1;
		for (i = 0; i < 16; i++)
		begin
			d = $random(seed);
			mem[i] = d & 32'hFFFFFFDF;
			m.acc(1'b1, 2'h2, dir(i[4:0]), d, 36'h0);
		end
		for (i = 0; i < 32; i++)
			m.acc(1'b0, 2'h2, dir(i[4:0]), 32'h0, i < 16 ? {4'h0, mem[i]} : {4'h8, 32'h0});
		m.acc(1'b0, 2'h2, CNT, 32'h0, {4'h0, 32'h10});
		m.acc(1'b1, 2'h2, CNT, $random(seed), 36'h0);
		m.acc(1'b0, 2'h2, CNT, 32'h0, {4'h0, 32'h10});
		for (i = 0; i < 4; i++)
		begin
			regionSelector = 8'(i * 5);
			d = $random(seed);
			mem[i * 5] = d & 32'hFFFFFFDF;
			m.acc(1'b1, 2'h2, SEL, d, 36'h0);
			m.acc(1'b0, 2'h2, dir(5'(i * 5)), 32'h0, {4'h0, mem[i * 5]});
			m.acc(1'b0, 2'h2, SEL, 32'h0, {4'h0, mem[i * 5]});
		end
		for (i = 0; i < 16; i++)
		begin
			{virtMemWriteTrap, virtMemReadTrap, hypGroup1Trap} = 3'(i >> 1);
			x = (hypGroup1Trap | (i[0] ? virtMemWriteTrap : virtMemReadTrap)) ? 4'h4 : {3'h1, i[0]};
			m.acc(i[0], 2'h1, SCR, 32'h0, {x, 32'h0});
		end
		generalExceptionTrap = 1'b1;
		m.acc(1'b0, 2'h1, SCR, 32'h0, {4'h8, 32'h0});
		generalExceptionTrap = 1'b0;
		m.acc(1'b0, 2'h0, SCR, 32'h0, {4'h8, 32'h0});
		for (i = 0; i < 8; i++)
		begin
			{hypLevelPresent, hypGroup0Trap, hypGroup6Trap} = 3'(i);
			m.acc(1'b0, 2'h1, CNT, 32'h0, {(hypLevelPresent & hypGroup0Trap) ? 4'h4 : 4'h8, 32'h0});
			m.acc(1'b1, 2'h1, SEL, d, {(hypLevelPresent & hypGroup6Trap) ? 4'h4 : 4'h8, 32'h0});
		end
		{hypGroup0Trap, hypGroup6Trap} = 2'h0;
		regionSelector = 8'h3;
		for (i = 0; i < 4; i++)
		begin
			d = $random(seed);
			d[5:0] = {1'b0, 2'(i), 2'(i), i[0]};
			m.acc(1'b1, 2'h2, SEL, d, 36'h0);
			for (j = 0; j < 16; j++)
			begin
				{chkWrite, stage2Enable, chkStage1Allow} = 3'(j);
				chkLevel = j[3] ? 2'h2 : 2'h1;
				m.idle;
				x[0] = (j[3] | stage2Enable) ? (!(i[1] & j[2]) & (j[3] | i[0]) & (j[3] | j[0])) : j[0];
				cmp(chkAllow, x[0], "permission result");
				cmp({selBaseAddr, selShareability, selShareReserved, selExecuteNever},
					{d[31:6], 6'h0, d[4:3], d[4:3] == 2'h1, d[0]}, "selected attributes");
			end
		end
		repeat (3) m.idle;
		cmp(m.expQ.size(), 0, "answers missing");
		printVerdict;
	end
endmodule // hmrb_core_tb

// ==== tb/hmrb_pipe_model.sv ====
// core pipeline side: issues coprocessor accesses and notes the expected answers
// assumes every call is made at a falling edge of clk_sys
`timescale 1ns/1ns
module hmrb_pipe_model
(
	// clock
	input  wire        clk_sys,
	// coprocessor access request
	output reg         reqValid,
	output reg         reqWrite,
	output reg  [1:0]  reqLevel,
	output reg  [3:0]  reqCoproc,
	output reg  [2:0]  reqOpc1,
	output reg  [3:0]  reqCrn,
	output reg  [3:0]  reqCrm,
	output reg  [2:0]  reqOpc2,
	output reg  [31:0] reqWdata
);
	reg [35:0] expQ[$];
	initial
	begin
		{reqValid, reqWrite, reqLevel, reqCoproc, reqOpc1, reqCrn, reqCrm, reqOpc2, reqWdata} = 54'h0;
	end
	// one access per call, held for exactly one edge
	task acc(input w, input [1:0] l, input [17:0] e, input [31:0] d, input [35:0] x);
	begin
		{reqValid, reqWrite, reqLevel} = {1'b1, w, l};
		{reqCoproc, reqOpc1, reqCrn, reqCrm, reqOpc2} = e;
		reqWdata = d;
		expQ.push_back(x);
		@(negedge clk_sys);
	end
	endtask
	// release: data no longer shows the last value
	task idle;
	begin
		reqValid = 1'b0;
		reqWdata = ~reqWdata;
		@(negedge clk_sys);
	end
	endtask
endmodule // hmrb_pipe_model
